// file: hw/fssr_pin_sync.sv
// Three-stage synchroniser that accepts a change once the last two stages agree.
`timescale 1ns/1ps
module fssr_pin_sync #(
   parameter int unsigned WIDTH = 1
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] level_out
);

   logic [WIDTH-1:0] stage1_q;
   logic [WIDTH-1:0] stage2_q;
   logic [WIDTH-1:0] stage3_q;
   logic [WIDTH-1:0] level_q;
   logic [WIDTH-1:0] agree;

   if (WIDTH < 1) begin : g_bad_width
      $error("fssr_pin_sync needs WIDTH of at least one");
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         stage1_q <= '0;
         stage2_q <= '0;
         stage3_q <= '0;
      end else begin
         stage1_q <= pin_in;
         stage2_q <= stage1_q;
         stage3_q <= stage2_q;
      end
   end

   assign agree = ~(stage2_q ^ stage3_q);

   always_ff @(posedge mclk) begin
      if (reset) begin
         level_q <= '0;
      end else begin
         level_q <= (level_q & ~agree) | (stage3_q & agree);
      end
   end

   assign level_out = level_q;

endmodule : fssr_pin_sync

// file: hw/fssr_status_bank.sv
// Read-only fault and system status register bank with its register read port.
`timescale 1ns/1ps

// Behaviour
// - Bit 23 follows thermal warning level.
// - Bit 22 follows thermal shutdown level.
// - Bits 21-16 per-switch overcurrent, C-high first.
// - Bit 14 shows storage error.
// - Bits 13,12 step-down overcurrent and undervoltage.
// - Bit 11 shows charge pump low.
// - Controller bit 31 ORs all faults.
// - Bits 29-27 position detection faults.
// - Bits 23-21 motor lock kinds.
// - Bit 20 set when any lock fires.
// - Bits 19,18 current limit faults.
// - Bits 17,16 supply low and high.
// - Bit 15 shows watchdog expiry.
// - Bits 2,1 self-test enable and pass.
// - Bit 0 shows application reset success.
// - Supply voltage tenths in bits 31-16.
// - Speed request in bits 15-1.
// - Bit 0 shows serial mode entered.
// - Sequencer state code in bits 31-28.
// - Bit 17 shows self-test failure.
// - All registers read-only, zero after reset.
// - Rotor rate tenths in bits 15-0.
module fssr_status_bank (
   input wire logic mclk,
   input wire logic reset,
   input wire fssr_pkg::fssr_req_type bus_req,
   input wire fssr_pkg::fssr_drv_in_type drv_pin,
   input wire fssr_pkg::fssr_ctl_in_type ctl_in,
   input wire fssr_pkg::fssr_sys_in_type sys_in,
   output logic [31:0] rd_data,
   output logic rd_valid,
   output logic wr_ack,
   output logic addr_err
);

   // ****************************************************************
   // Declarations.
   // ****************************************************************
   fssr_pkg::fssr_drv_in_type drv_s;
   logic [31:0] drv_d, drv_q;
   logic [31:0] ctl_d, ctl_q;
   logic [31:0] sys1_d, sys1_q;
   logic [31:0] sys2_d, sys2_q;
   logic [31:0] sys3_d, sys3_q;
   logic [31:0] rd_mux;
   logic [31:0] rd_data_q;
   logic rd_valid_q;
   logic wr_ack_q;
   logic addr_err_q;
   logic any_lock;
   logic any_ctl_fault;

   function automatic logic is_mapped(input logic [fssr_pkg::ADDR_W-1:0] a);
      logic hit;
      hit = 1'b0;
      if (a == fssr_pkg::OFS_POWER_STAGE) begin
         hit = 1'b1;
      end else if (a == fssr_pkg::OFS_CONTROLLER) begin
         hit = 1'b1;
      end else if (a == fssr_pkg::OFS_SUPPLY_SPEED) begin
         hit = 1'b1;
      end else if (a == fssr_pkg::OFS_SEQ_RATE) begin
         hit = 1'b1;
      end else if (a == fssr_pkg::OFS_BUS_POWER) begin
         hit = 1'b1;
      end
      return hit;
   endfunction : is_mapped

   // ****************************************************************
   // Analog fault comparators arrive asynchronously and are synchronised.
   // ****************************************************************
   fssr_pin_sync #(
      .WIDTH($bits(fssr_pkg::fssr_drv_in_type))
   ) u_drv_sync (
      .mclk(mclk),
      .reset(reset),
      .pin_in(drv_pin),
      .level_out(drv_s)
   );

   // ****************************************************************
   // Next values of the status words.
   // ****************************************************************
   always_comb begin
      drv_d = fssr_pkg::STATUS_RESET;
      drv_d[fssr_pkg::DRV_THERMAL_WARN_BIT] = drv_s.thermal_warning_flag;
      drv_d[fssr_pkg::DRV_THERMAL_SHUT_BIT] = drv_s.thermal_shutdown_flag;
      drv_d[fssr_pkg::DRV_OVERCURRENT_MSB:fssr_pkg::DRV_OVERCURRENT_LSB] = {
         drv_s.phase_c_high_switch_overcurrent,
         drv_s.phase_c_low_switch_overcurrent,
         drv_s.phase_b_high_switch_overcurrent,
         drv_s.phase_b_low_switch_overcurrent,
         drv_s.phase_a_high_switch_overcurrent,
         drv_s.phase_a_low_switch_overcurrent};
      drv_d[fssr_pkg::DRV_OTP_ERROR_BIT] = drv_s.otp_storage_error;
      drv_d[fssr_pkg::DRV_STEPDOWN_OC_BIT] = drv_s.stepdown_overcurrent_flag;
      drv_d[fssr_pkg::DRV_STEPDOWN_UV_BIT] = drv_s.stepdown_undervoltage_flag;
      drv_d[fssr_pkg::DRV_CHARGE_PUMP_BIT] = drv_s.charge_pump_low_flag;
   end

   assign any_lock = ctl_in.abnormal_rate_lock | ctl_in.sync_lost_lock
      | ctl_in.absent_motor_lock;

   // Self-test and reset outcome bits are status, not faults, so they stay out of the summary.
   assign any_ctl_fault = ctl_in.position_detect_frequency_fault
      | ctl_in.position_detect_timing1_fault | ctl_in.position_detect_timing2_fault
      | any_lock | ctl_in.cycle_current_limit_fault | ctl_in.lock_current_limit_fault
      | ctl_in.motor_supply_low_fault | ctl_in.motor_supply_high_fault
      | ctl_in.host_watchdog_expired;

   always_comb begin
      ctl_d = fssr_pkg::STATUS_RESET;
      ctl_d[fssr_pkg::CTL_ANY_FAULT_BIT] = any_ctl_fault;
      ctl_d[fssr_pkg::CTL_POS_FREQ_BIT] = ctl_in.position_detect_frequency_fault;
      ctl_d[fssr_pkg::CTL_POS_T1_BIT] = ctl_in.position_detect_timing1_fault;
      ctl_d[fssr_pkg::CTL_POS_T2_BIT] = ctl_in.position_detect_timing2_fault;
      ctl_d[fssr_pkg::CTL_ABN_RATE_BIT] = ctl_in.abnormal_rate_lock;
      ctl_d[fssr_pkg::CTL_SYNC_LOST_BIT] = ctl_in.sync_lost_lock;
      ctl_d[fssr_pkg::CTL_NO_MOTOR_BIT] = ctl_in.absent_motor_lock;
      ctl_d[fssr_pkg::CTL_ANY_LOCK_BIT] = any_lock;
      ctl_d[fssr_pkg::CTL_CYCLE_LIM_BIT] = ctl_in.cycle_current_limit_fault;
      ctl_d[fssr_pkg::CTL_LOCK_LIM_BIT] = ctl_in.lock_current_limit_fault;
      ctl_d[fssr_pkg::CTL_SUPPLY_LOW_BIT] = ctl_in.motor_supply_low_fault;
      ctl_d[fssr_pkg::CTL_SUPPLY_HIGH_BIT] = ctl_in.motor_supply_high_fault;
      ctl_d[fssr_pkg::CTL_WATCHDOG_BIT] = ctl_in.host_watchdog_expired;
      ctl_d[fssr_pkg::CTL_SELFTEST_EN_BIT] = ctl_in.selftest_enabled;
      ctl_d[fssr_pkg::CTL_SELFTEST_OK_BIT] = ctl_in.selftest_passed;
      ctl_d[fssr_pkg::CTL_APP_RESET_BIT] = ctl_in.app_reset_ok;
   end

   always_comb begin
      sys1_d = fssr_pkg::STATUS_RESET;
      sys1_d[fssr_pkg::SYS1_VOLT_LSB +: 16] = sys_in.supply_voltage_tenths;
      sys1_d[fssr_pkg::SYS1_SPEED_LSB +: 15] = sys_in.speed_request;
      sys1_d[fssr_pkg::SYS1_ENTRY_BIT] = sys_in.serial_entry_flag;
   end

   always_comb begin
      sys2_d = fssr_pkg::STATUS_RESET;
      sys2_d[fssr_pkg::SYS2_STATE_LSB +: 4] = sys_in.sequencer_state;
      sys2_d[fssr_pkg::SYS2_SELFTEST_FAIL_BIT] = sys_in.selftest_failed;
      sys2_d[fssr_pkg::SYS2_RATE_LSB +: 16] = sys_in.rotor_rate_tenths;
   end

   always_comb begin
      sys3_d = fssr_pkg::STATUS_RESET;
      sys3_d[fssr_pkg::SYS3_CURRENT_LSB +: 16] = sys_in.bus_current;
      sys3_d[fssr_pkg::SYS3_POWER_LSB +: 16] = sys_in.input_power;
   end

   // ****************************************************************
   // Status words track their sources; only reset loads them otherwise.
   // ****************************************************************
   always_ff @(posedge mclk) begin
      if (reset) begin
         drv_q <= fssr_pkg::STATUS_RESET;
      end else begin
         drv_q <= drv_d;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         ctl_q <= fssr_pkg::STATUS_RESET;
      end else begin
         ctl_q <= ctl_d;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         sys1_q <= fssr_pkg::STATUS_RESET;
         sys2_q <= fssr_pkg::STATUS_RESET;
         sys3_q <= fssr_pkg::STATUS_RESET;
      end else begin
         sys1_q <= sys1_d;
         sys2_q <= sys2_d;
         sys3_q <= sys3_d;
      end
   end

   // ****************************************************************
   // Register read port. Writes without a read are acknowledged; all writes are discarded.
   // ****************************************************************
   always_comb begin
      rd_mux = fssr_pkg::STATUS_RESET;
      if (bus_req.addr == fssr_pkg::OFS_POWER_STAGE) begin
         rd_mux = drv_q;
      end else if (bus_req.addr == fssr_pkg::OFS_CONTROLLER) begin
         rd_mux = ctl_q;
      end else if (bus_req.addr == fssr_pkg::OFS_SUPPLY_SPEED) begin
         rd_mux = sys1_q;
      end else if (bus_req.addr == fssr_pkg::OFS_SEQ_RATE) begin
         rd_mux = sys2_q;
      end else if (bus_req.addr == fssr_pkg::OFS_BUS_POWER) begin
         rd_mux = sys3_q;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         rd_data_q <= fssr_pkg::STATUS_RESET;
         rd_valid_q <= 1'b0;
      end else begin
         rd_valid_q <= bus_req.rd_en;
         if (bus_req.rd_en) begin
            rd_data_q <= rd_mux;
         end
      end
   end

   // No path leads from wr_data into any status word.
   always_ff @(posedge mclk) begin
      if (reset) begin
         wr_ack_q <= 1'b0;
      end else begin
         wr_ack_q <= bus_req.wr_en & ~bus_req.rd_en;
      end
   end

   // Unmapped accesses read zero and raise a one-cycle error pulse.
   always_ff @(posedge mclk) begin
      if (reset) begin
         addr_err_q <= 1'b0;
      end else begin
         addr_err_q <= (bus_req.rd_en | bus_req.wr_en) & ~is_mapped(bus_req.addr);
      end
   end

   assign rd_data = rd_data_q;
   assign rd_valid = rd_valid_q;
   assign wr_ack = wr_ack_q;
   assign addr_err = addr_err_q;

   // ****************************************************************
   // Checks.
   // ****************************************************************
   logic [5:0] ocp_pin;
   assign ocp_pin = {drv_pin.phase_c_high_switch_overcurrent, drv_pin.phase_c_low_switch_overcurrent,
      drv_pin.phase_b_high_switch_overcurrent, drv_pin.phase_b_low_switch_overcurrent,
      drv_pin.phase_a_high_switch_overcurrent, drv_pin.phase_a_low_switch_overcurrent};

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   chk_warn_set: assert property (
      (drv_pin.thermal_warning_flag)[*7] |-> drv_q[fssr_pkg::DRV_THERMAL_WARN_BIT])
      else $error("thermal warning bit not set after steady input");
   chk_warn_clear: assert property (
      (!drv_pin.thermal_warning_flag)[*7] |-> !drv_q[fssr_pkg::DRV_THERMAL_WARN_BIT])
      else $error("thermal warning bit not cleared after steady input");
   chk_shutdown_set: assert property (
      (drv_pin.thermal_shutdown_flag)[*7] |-> drv_q[fssr_pkg::DRV_THERMAL_SHUT_BIT])
      else $error("thermal shutdown bit not set after steady input");
   chk_switch_order: assert property (
      ($stable(ocp_pin))[*6] |-> drv_q[21:16] == ocp_pin)
      else $error("switch overcurrent bits out of order or stale");
   chk_fault_summary: assert property (
      ctl_q[fssr_pkg::CTL_ANY_FAULT_BIT] == (|ctl_q[29:fssr_pkg::CTL_FAULT_LSB]))
      else $error("controller fault summary disagrees with fault bits");
   chk_lock_summary: assert property (
      ctl_q[fssr_pkg::CTL_ANY_LOCK_BIT] == (|ctl_q[23:21]))
      else $error("motor lock summary disagrees with lock bits");
   chk_reset_zero: assert property (@(posedge mclk) disable iff (1'b0)
      reset |=> (drv_q | ctl_q | sys1_q | sys2_q | sys3_q | rd_data_q) == 32'h0000_0000)
      else $error("status not zero after reset");
   chk_write_ignored: assert property (
      bus_req.wr_en && !bus_req.rd_en |=> wr_ack && $stable(rd_data))
      else $error("write disturbed read data or was not acknowledged");
   chk_state_read: assert property (
      bus_req.rd_en && bus_req.addr == fssr_pkg::OFS_SEQ_RATE
      |=> rd_valid && rd_data[31:28] == $past(sys2_q[31:28]))
      else $error("state code read back wrong");
   chk_supply_read: assert property (
      bus_req.rd_en && bus_req.addr == fssr_pkg::OFS_SUPPLY_SPEED
      |=> rd_data == $past(sys1_q))
      else $error("supply word read back wrong");
   chk_unmapped_zero: assert property (
      bus_req.rd_en && !is_mapped(bus_req.addr) |=> addr_err && rd_data == 32'h0000_0000)
      else $error("unmapped read not zero or not flagged");
   chk_storage_set: assert property (
      (drv_pin.otp_storage_error)[*7] |-> drv_q[fssr_pkg::DRV_OTP_ERROR_BIT])
      else $error("storage error bit not set after steady input");
   chk_pump_set: assert property (
      (drv_pin.charge_pump_low_flag)[*7] |-> drv_q[fssr_pkg::DRV_CHARGE_PUMP_BIT])
      else $error("charge pump bit not set after steady input");
   chk_watchdog_set: assert property (
      ctl_in.host_watchdog_expired |=> ctl_q[fssr_pkg::CTL_WATCHDOG_BIT])
      else $error("watchdog bit not set one cycle after expiry");
   chk_dual_no_ack: assert property (
      bus_req.rd_en && bus_req.wr_en |=> rd_valid && !wr_ack)
      else $error("combined access acknowledged a write");

   cov_fault_state: cover property (sys2_q[31:28] == fssr_pkg::SEQ_FAULT);
   cov_lock_read: cover property (bus_req.rd_en && bus_req.addr == fssr_pkg::OFS_CONTROLLER
      ##1 rd_data[fssr_pkg::CTL_ANY_LOCK_BIT]);
   cov_warn_seen: cover property ($rose(drv_q[fssr_pkg::DRV_THERMAL_WARN_BIT]));
   cov_read_write: cover property (bus_req.rd_en && bus_req.wr_en);

endmodule : fssr_status_bank

// file: include/fssr_pkg.sv
// Offsets, field positions, reset values, codes and carrier types of the status bank.
package fssr_pkg;

   // ****************************************************************
   // Register offsets on the 8-bit serial register index.
   // ****************************************************************
   localparam int unsigned ADDR_W = 8;
   localparam logic [7:0] OFS_POWER_STAGE = 8'hE0;
   localparam logic [7:0] OFS_CONTROLLER = 8'hE2;
   localparam logic [7:0] OFS_SUPPLY_SPEED = 8'hE4;
   localparam logic [7:0] OFS_SEQ_RATE = 8'hEA;
   localparam logic [7:0] OFS_BUS_POWER = 8'hEC;

   localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

   // ****************************************************************
   // Power stage fault word.
   // ****************************************************************
   localparam int unsigned DRV_THERMAL_WARN_BIT = 23;
   localparam int unsigned DRV_THERMAL_SHUT_BIT = 22;
   localparam int unsigned DRV_OVERCURRENT_MSB = 21;
   localparam int unsigned DRV_OVERCURRENT_LSB = 16;
   localparam int unsigned DRV_OTP_ERROR_BIT = 14;
   localparam int unsigned DRV_STEPDOWN_OC_BIT = 13;
   localparam int unsigned DRV_STEPDOWN_UV_BIT = 12;
   localparam int unsigned DRV_CHARGE_PUMP_BIT = 11;

   // ****************************************************************
   // Controller fault word.
   // ****************************************************************
   localparam int unsigned CTL_ANY_FAULT_BIT = 31;
   localparam int unsigned CTL_POS_FREQ_BIT = 29;
   localparam int unsigned CTL_POS_T1_BIT = 28;
   localparam int unsigned CTL_POS_T2_BIT = 27;
   localparam int unsigned CTL_ABN_RATE_BIT = 23;
   localparam int unsigned CTL_SYNC_LOST_BIT = 22;
   localparam int unsigned CTL_NO_MOTOR_BIT = 21;
   localparam int unsigned CTL_ANY_LOCK_BIT = 20;
   localparam int unsigned CTL_CYCLE_LIM_BIT = 19;
   localparam int unsigned CTL_LOCK_LIM_BIT = 18;
   localparam int unsigned CTL_SUPPLY_LOW_BIT = 17;
   localparam int unsigned CTL_SUPPLY_HIGH_BIT = 16;
   localparam int unsigned CTL_WATCHDOG_BIT = 15;
   localparam int unsigned CTL_FAULT_LSB = 15;
   localparam int unsigned CTL_SELFTEST_EN_BIT = 2;
   localparam int unsigned CTL_SELFTEST_OK_BIT = 1;
   localparam int unsigned CTL_APP_RESET_BIT = 0;

   // ****************************************************************
   // System status words.
   // ****************************************************************
   localparam int unsigned SYS1_VOLT_LSB = 16;
   localparam int unsigned SYS1_SPEED_LSB = 1;
   localparam int unsigned SYS1_ENTRY_BIT = 0;
   localparam int unsigned SYS2_STATE_LSB = 28;
   localparam int unsigned SYS2_SELFTEST_FAIL_BIT = 17;
   localparam int unsigned SYS2_RATE_LSB = 0;
   localparam int unsigned SYS3_CURRENT_LSB = 16;
   localparam int unsigned SYS3_POWER_LSB = 0;

   // ****************************************************************
   // Sequencer state codes.
   // ****************************************************************
   localparam logic [3:0] SEQ_SYSTEM_IDLE = 4'h0;
   localparam logic [3:0] SEQ_START = 4'h1;
   localparam logic [3:0] SEQ_RUN = 4'h2;
   localparam logic [3:0] SEQ_INIT = 4'h3;
   localparam logic [3:0] SEQ_POSITION_DETECT = 4'h4;
   localparam logic [3:0] SEQ_ALIGN = 4'h5;
   localparam logic [3:0] SEQ_MOTOR_IDLE = 4'h6;
   localparam logic [3:0] SEQ_STOP = 4'h7;
   localparam logic [3:0] SEQ_FAULT = 4'h8;
   localparam logic [3:0] SEQ_DIRECTION = 4'h9;
   localparam logic [3:0] SEQ_SENSOR_ALIGN = 4'hA;
   localparam logic [3:0] SEQ_FREEWHEEL = 4'hC;
   localparam logic [3:0] SEQ_DECELERATE = 4'hD;
   localparam logic [3:0] SEQ_BRAKE = 4'hE;

   localparam int unsigned SYNC_STAGES = 3;

   // ****************************************************************
   // Carrier types.
   // ****************************************************************
   typedef struct packed {
      logic thermal_warning_flag;
      logic thermal_shutdown_flag;
      logic phase_c_high_switch_overcurrent;
      logic phase_c_low_switch_overcurrent;
      logic phase_b_high_switch_overcurrent;
      logic phase_b_low_switch_overcurrent;
      logic phase_a_high_switch_overcurrent;
      logic phase_a_low_switch_overcurrent;
      logic otp_storage_error;
      logic stepdown_overcurrent_flag;
      logic stepdown_undervoltage_flag;
      logic charge_pump_low_flag;
   } fssr_drv_in_type;

   typedef struct packed {
      logic position_detect_frequency_fault;
      logic position_detect_timing1_fault;
      logic position_detect_timing2_fault;
      logic abnormal_rate_lock;
      logic sync_lost_lock;
      logic absent_motor_lock;
      logic cycle_current_limit_fault;
      logic lock_current_limit_fault;
      logic motor_supply_low_fault;
      logic motor_supply_high_fault;
      logic host_watchdog_expired;
      logic selftest_enabled;
      logic selftest_passed;
      logic app_reset_ok;
   } fssr_ctl_in_type;

   typedef struct packed {
      logic [15:0] supply_voltage_tenths;
      logic [14:0] speed_request;
      logic serial_entry_flag;
      logic [3:0] sequencer_state;
      logic selftest_failed;
      logic [15:0] rotor_rate_tenths;
      logic [15:0] bus_current;
      logic [15:0] input_power;
   } fssr_sys_in_type;

   typedef struct packed {
      logic rd_en;
      logic wr_en;
      logic [ADDR_W-1:0] addr;
      logic [31:0] wr_data;
   } fssr_req_type;

endpackage : fssr_pkg

// file: verif/fssr_host_model.sv
// Host model that issues register reads and writes on the status bank port.
`timescale 1ns/1ps
module fssr_host_model (
   input wire logic mclk,
   output fssr_pkg::fssr_req_type bus_req
);
   initial begin
      bus_req = '0;
   end

   // ****************************************************************
   // Requests. Each task is entered just after a rising edge and leaves its
   // request standing, so calls run back to back until idle is called.
   // ****************************************************************
   task automatic read_word(input logic [7:0] addr, input logic with_wr = 1'b0);
      bus_req.rd_en = 1'b1;
      bus_req.wr_en = with_wr;
      bus_req.addr = addr;
      bus_req.wr_data = ~bus_req.wr_data;
      @(posedge mclk);
      #1;
   endtask : read_word

   task automatic write_word(input logic [7:0] addr, input logic [31:0] data);
      if (addr inside {fssr_pkg::OFS_POWER_STAGE, fssr_pkg::OFS_CONTROLLER,
         fssr_pkg::OFS_SUPPLY_SPEED, fssr_pkg::OFS_SEQ_RATE, fssr_pkg::OFS_BUS_POWER}) begin
         bus_req.rd_en = 1'b0;
         bus_req.wr_en = 1'b1;
         bus_req.addr = addr;
         bus_req.wr_data = data;
         @(posedge mclk);
         #1;
      end
   endtask : write_word

   task automatic idle();
      bus_req.rd_en = 1'b0;
      bus_req.wr_en = 1'b0;
      bus_req.addr = ~bus_req.addr;
      bus_req.wr_data = ~bus_req.wr_data;
      @(posedge mclk);
      #1;
   endtask : idle
endmodule : fssr_host_model

// file: verif/testbench.sv
// Self-checking bench for the status register bank.
`timescale 1ns/1ps
module testbench;
   typedef struct packed {
      logic is_read;
      logic err;
      logic [31:0] data;
   } fssr_note_type;
   logic mclk;
   logic reset;
   fssr_pkg::fssr_req_type bus_req;
   fssr_pkg::fssr_drv_in_type drv_pin;
   fssr_pkg::fssr_ctl_in_type ctl_in;
   fssr_pkg::fssr_sys_in_type sys_in;
   logic [31:0] rd_data;
   logic rd_valid;
   logic wr_ack;
   logic addr_err;
   fssr_note_type exp_q[$];
   int err_total = 0;
   int num_checks = 0;
   int cycles = 0;

   fssr_status_bank dut_u (
      .mclk(mclk),
      .reset(reset),
      .bus_req(bus_req),
      .drv_pin(drv_pin),
      .ctl_in(ctl_in),
      .sys_in(sys_in),
      .rd_data(rd_data),
      .rd_valid(rd_valid),
      .wr_ack(wr_ack),
      .addr_err(addr_err)
   );

   fssr_host_model host_u (
      .mclk(mclk),
      .bus_req(bus_req)
   );

   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   // ****************************************************************
   // Expectations and comparisons.
   // ****************************************************************
   function automatic fssr_note_type read_note(input logic [7:0] a);
      fssr_note_type n;
      n = {1'b1, 1'b0, 32'h0000_0000};
      case (a)
         fssr_pkg::OFS_POWER_STAGE: n.data = {8'h00, drv_pin[11:4], 1'b0, drv_pin[3:0], 11'h000};
         fssr_pkg::OFS_CONTROLLER: n.data = {|ctl_in[13:3], 1'b0, ctl_in[13:11], 3'h0,
            ctl_in[10:8], |ctl_in[10:8], ctl_in[7:3], 12'h000, ctl_in[2:0]};
         fssr_pkg::OFS_SUPPLY_SPEED: n.data = {sys_in.supply_voltage_tenths,
            sys_in.speed_request, sys_in.serial_entry_flag};
         fssr_pkg::OFS_SEQ_RATE: n.data = {sys_in.sequencer_state, 10'h000,
            sys_in.selftest_failed, 1'b0, sys_in.rotor_rate_tenths};
         fssr_pkg::OFS_BUS_POWER: n.data = {sys_in.bus_current, sys_in.input_power};
         default: n.err = 1'b1;
      endcase
      return n;
   endfunction : read_note

   task automatic compare(input logic [33:0] e, input logic [33:0] g);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : compare

   task automatic check_read(input fssr_note_type n);
      compare({1'b1, n.err, n.data}, {rd_valid & ~wr_ack, addr_err, rd_data});
   endtask : check_read

   task automatic check_write();
      compare({32'h0000_0000, 2'b10}, {31'h0000_0000, rd_valid, wr_ack, addr_err});
   endtask : check_write

   always @(negedge mclk) begin
      if (rd_valid === 1'b1 || wr_ack === 1'b1 || addr_err === 1'b1) begin
         if (exp_q.size() == 0) begin
            compare(34'h0_0000_0000, {31'h0000_0000, rd_valid, wr_ack, addr_err});
         end else if (exp_q[0].is_read) begin
            check_read(exp_q.pop_front());
         end else begin
            void'(exp_q.pop_front());
            check_write();
         end
      end
   end

   // ****************************************************************
   // Stimulus.
   // ****************************************************************
   task automatic set_inputs(input logic [3:0] state);
      drv_pin = 12'($urandom);
      ctl_in = 14'($urandom);
      sys_in = 85'({$urandom, $urandom, $urandom});
      sys_in.sequencer_state = state;
   endtask : set_inputs

   task automatic do_read(input logic [7:0] a);
      exp_q.push_back(read_note(a));
      host_u.read_word(a);
   endtask : do_read

   task automatic apply_reset();
      reset = 1'b1;
      set_inputs(4'h7);
      repeat (4) @(posedge mclk);
      #1;
      reset = 1'b0;
      exp_q.push_back({1'b1, 1'b0, 32'h0000_0000});
      host_u.read_word(fssr_pkg::OFS_CONTROLLER);
      do_read(fssr_pkg::OFS_SUPPLY_SPEED);
      host_u.idle();
   endtask : apply_reset

   task automatic summarize();
      $display("checks=%0d mismatches=%0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : summarize

   always @(posedge mclk) begin
      cycles++;
      if (cycles >= 3000) begin
         err_total++;
         summarize();
      end
   end

   initial begin
      void'($urandom(32'hdeb6_51c9));
      apply_reset();
      $display("test reset_values done");
      for (int i = 0; i < 16; i++) begin
         set_inputs(i[3:0]);
         repeat (8) @(posedge mclk);
         #1;
         do_read(fssr_pkg::OFS_POWER_STAGE);
         do_read(fssr_pkg::OFS_CONTROLLER);
         do_read(fssr_pkg::OFS_CONTROLLER);
         do_read(fssr_pkg::OFS_SUPPLY_SPEED);
         do_read(fssr_pkg::OFS_SEQ_RATE);
         do_read(fssr_pkg::OFS_BUS_POWER);
         do_read(8'hE6);
         host_u.idle();
      end
      $display("test field_mapping done");
      for (int k = 0; k < 5; k++) begin
         exp_q.push_back({1'b0, 1'b0, 32'h0000_0000});
         host_u.write_word(k == 0 ? fssr_pkg::OFS_POWER_STAGE :
            k == 1 ? fssr_pkg::OFS_CONTROLLER : k == 2 ? fssr_pkg::OFS_SUPPLY_SPEED :
            k == 3 ? fssr_pkg::OFS_SEQ_RATE : fssr_pkg::OFS_BUS_POWER, $urandom);
      end
      exp_q.push_back(read_note(fssr_pkg::OFS_SUPPLY_SPEED));
      host_u.read_word(fssr_pkg::OFS_SUPPLY_SPEED, 1'b1);
      host_u.idle();
      do_read(fssr_pkg::OFS_POWER_STAGE);
      do_read(fssr_pkg::OFS_CONTROLLER);
      do_read(fssr_pkg::OFS_SUPPLY_SPEED);
      do_read(fssr_pkg::OFS_SEQ_RATE);
      do_read(fssr_pkg::OFS_BUS_POWER);
      host_u.idle();
      $display("test ignored_writes done");
      apply_reset();
      $display("test mid_run_reset done");
      repeat (3) @(posedge mclk);
      compare(34'h0_0000_0000, 34'(exp_q.size()));
      summarize();
   end
endmodule : testbench
